// *** rtl/crt_vtiming_pkg.sv ***
package crt_vtiming_pkg;

	// ============================================================
	// Register indices on the index/data port.
	localparam logic [5:0] IDX_VERTICAL_TOTAL_LOW = 6'h06;
	localparam logic [5:0] IDX_VERTICAL_OVERFLOW = 6'h07;
	localparam logic [5:0] IDX_PRESET_ROW_AND_PAN = 6'h08;
	localparam logic [5:0] IDX_MAX_SCAN_LINE_CTRL = 6'h09;
	localparam logic [5:0] IDX_CURSOR_START_ROW = 6'h0a;
	localparam logic [5:0] IDX_CURSOR_END_ROW = 6'h0b;
	localparam logic [5:0] IDX_START_ADDRESS_MIDDLE = 6'h0c;
	localparam logic [5:0] IDX_START_ADDRESS_LOW = 6'h0d;
	localparam logic [5:0] IDX_CURSOR_LOCATION_HIGH = 6'h0e;
	localparam logic [5:0] IDX_CURSOR_LOCATION_LOW = 6'h0f;
	localparam logic [5:0] IDX_VERTICAL_SYNC_START_LOW = 6'h10;
	localparam logic [5:0] IDX_VERTICAL_SYNC_END_IRQ = 6'h11;
	localparam logic [5:0] IDX_VERTICAL_DISPLAY_END_LOW = 6'h12;
	localparam logic [5:0] IDX_LINE_PITCH_LOW = 6'h13;
	// Highest index that the protect bit covers.
	localparam logic [5:0] IDX_PROTECT_LAST = 6'h07;

	// ============================================================
	// Field positions in the overflow register.
	localparam int OVF_VTOTAL_B8 = 0;
	localparam int OVF_VDISPEND_B8 = 1;
	localparam int OVF_VSYNCSTR_B8 = 2;
	localparam int OVF_VBLKSTR_B8 = 3;
	localparam int OVF_LINECOMP_B8 = 4;
	localparam int OVF_VTOTAL_B9 = 5;
	localparam int OVF_VDISPEND_B9 = 6;
	localparam int OVF_VSYNCSTR_B9 = 7;

	// Field positions in the maximum scan line register.
	localparam int MSL_VBLKSTR_B9 = 5;
	localparam int MSL_LINECOMP_B9 = 6;
	localparam int MSL_LINE_DOUBLING = 7;

	// Field positions in the preset row, cursor and sync end registers.
	localparam int PRS_PAN_LSB = 5;
	localparam int CUR_OFF_BIT = 5;
	localparam int CUR_SKEW_LSB = 5;
	localparam int VSE_INT_CLEAR = 4;
	localparam int VSE_INT_DISABLE = 5;
	localparam int VSE_REFRESH_SELECT = 6;
	localparam int VSE_PROTECT = 7;

	// Field positions in the vertical extension register.
	localparam int VEXT_VTOTAL_LSB = 0;
	localparam int VEXT_VDISPEND_B10 = 2;
	localparam int VEXT_VSYNCSTR_LSB = 5;

	// Readable bits of registers with reserved bits.
	localparam logic [7:0] PRS_READ_MASK = 8'h7f;
	localparam logic [7:0] CSR_READ_MASK = 8'h3f;
	localparam logic [7:0] CER_READ_MASK = 8'h7f;

	// Value of every register after reset, and the depth of the cursor skew pipe.
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [11:0] VCNT_RESET = 12'h000;
	localparam logic [4:0] ROW_RESET = 5'h00;
	localparam int SKEW_DEPTH = 4;

endpackage : crt_vtiming_pkg

// *** rtl/crt_vertical_timing_cursor_regs.sv ***
`timescale 1ns/1ps
// Summary of operation
// - Vertical total is 12 bits from total, overflow and extension fields.
// - Protect bit blocks writes to indices 0 to 7, except line-compare bit 8.
// - Overflow bits 0-4 carry bit 8 fields, bits 5-7 carry bit 9 fields.
// - Max scan register bit 5 is blank start bit 9, bit 6 compare bit 9.
// - Row counter loads preset after retrace, clears on max scan compare.
// - Preset counts single lines, or double lines when line doubling is set.
// - Max scan field is scan lines per character row minus one.
// - Line doubling selects row counter clock and start address load time.
// - Cursor spans start to end row; none when start exceeds end.
// - Cursor-off bit suppresses the cursor.
// - Cursor skew delays the cursor by zero to three character clocks.
// - 21-bit start address from nibble, middle and low bytes, used after retrace.
// - Cursor sits at the 16-bit location, only in alphanumeric mode.
// - Vertical sync starts when the line counter equals the 12-bit start.
// - Vertical sync ends when counter low four bits equal the end field.
// - Interrupt-clear at zero clears the request; software writes one to rearm.
// - Active-low enable gates the request onto the registered interrupt, one clock later.
// - Refresh-select bit is read/write and has no effect.
// - Display enable drops when the counter reaches the 11-bit end value.
// - Sync halving advances the vertical counter on every second line.
// - Index written first, then data read or written through the data byte.
module crt_vertical_timing_cursor_regs (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic index_wr,
	input wire logic [5:0] index_wdata,
	input wire logic data_wr,
	input wire logic [7:0] data_wdata,
	input wire logic [3:0] address_extension_reg,
	input wire logic [7:0] vertical_extension_reg,
	input wire logic sync_halving,
	input wire logic alpha_mode,
	input wire logic hretrace,
	input wire logic [15:0] char_addr,
	input wire logic char_valid,
	output logic [5:0] index_r,
	output logic [7:0] rdata_r,
	output logic [11:0] vcount_r,
	output logic [4:0] row_scan_r,
	output logic vsync_r,
	output logic vdisp_en_r,
	output logic [20:0] start_addr_r,
	output logic cursor_r,
	output logic vint_req_r,
	output logic irq_r,
	output logic [1:0] byte_pan_r,
	output logic [7:0] line_pitch_r
);

	// ============================================================
	// Register storage
	logic [7:0] vertical_total_low_r, vertical_overflow_reg_r, preset_row_and_pan_r;
	logic [7:0] max_scan_reg_r, cursor_start_row_r, cursor_end_row_r, start_address_middle_r;
	logic [7:0] start_address_low_r, cursor_location_high_r, cursor_location_low_r;
	logic [7:0] vertical_sync_start_low_r, vertical_sync_end_irq_r, vertical_display_end_low_r;

	// Timing state
	localparam int SKEW_DEPTH_W = crt_vtiming_pkg::SKEW_DEPTH;
	logic line_div_r, row_div_r, addr_load_pend_r;
	logic [SKEW_DEPTH_W-1:0] cursor_pipe_r;

	// Decoded fields
	logic protect, line_doubling, int_clear_n, int_disable_n_low;
	logic [11:0] vtotal, vsync_start;
	logic [10:0] vdisp_end;
	logic [4:0] preset_row, max_scan, cur_start, cur_end;
	logic [1:0] cur_skew;
	logic [3:0] vsync_end;
	logic [20:0] start_addr_full;
	logic [15:0] cursor_loc;
	logic line_tick, row_tick, frame_end, vsync_begin, cursor_now, wr_ok;
	logic [7:0] rd_mux;

	// ============================================================
	// Field assembly from the byte registers and extension inputs.
	assign protect = vertical_sync_end_irq_r[crt_vtiming_pkg::VSE_PROTECT];
	assign line_doubling = max_scan_reg_r[crt_vtiming_pkg::MSL_LINE_DOUBLING];
	assign int_clear_n = vertical_sync_end_irq_r[crt_vtiming_pkg::VSE_INT_CLEAR];
	assign int_disable_n_low = ~vertical_sync_end_irq_r[crt_vtiming_pkg::VSE_INT_DISABLE];
	assign vtotal = {vertical_extension_reg[crt_vtiming_pkg::VEXT_VTOTAL_LSB+1],
		vertical_extension_reg[crt_vtiming_pkg::VEXT_VTOTAL_LSB],
		vertical_overflow_reg_r[crt_vtiming_pkg::OVF_VTOTAL_B9],
		vertical_overflow_reg_r[crt_vtiming_pkg::OVF_VTOTAL_B8],
		vertical_total_low_r};
	assign vsync_start = {vertical_extension_reg[crt_vtiming_pkg::VEXT_VSYNCSTR_LSB+1],
		vertical_extension_reg[crt_vtiming_pkg::VEXT_VSYNCSTR_LSB],
		vertical_overflow_reg_r[crt_vtiming_pkg::OVF_VSYNCSTR_B9],
		vertical_overflow_reg_r[crt_vtiming_pkg::OVF_VSYNCSTR_B8],
		vertical_sync_start_low_r};
	assign vdisp_end = {vertical_extension_reg[crt_vtiming_pkg::VEXT_VDISPEND_B10],
		vertical_overflow_reg_r[crt_vtiming_pkg::OVF_VDISPEND_B9],
		vertical_overflow_reg_r[crt_vtiming_pkg::OVF_VDISPEND_B8],
		vertical_display_end_low_r};
	assign preset_row = preset_row_and_pan_r[4:0];
	assign max_scan = max_scan_reg_r[4:0];
	assign cur_start = cursor_start_row_r[4:0];
	assign cur_end = cursor_end_row_r[4:0];
	assign cur_skew = cursor_end_row_r[crt_vtiming_pkg::CUR_SKEW_LSB +: 2];
	assign vsync_end = vertical_sync_end_irq_r[3:0];
	assign start_addr_full = {1'b0, address_extension_reg, start_address_middle_r,
		start_address_low_r};
	assign cursor_loc = {cursor_location_high_r, cursor_location_low_r};

	// ============================================================
	// Line and row clocking.
	// Sync halving passes every second retrace, so all vertical values
	// gain a resolution of two lines.
	assign line_tick = hretrace & (~sync_halving | line_div_r);
	// Line doubling clocks the row counter on every second counted line.
	assign row_tick = line_tick & (~line_doubling | row_div_r);
	assign frame_end = line_tick & (vcount_r == vtotal);
	assign vsync_begin = line_tick & (vcount_r == vsync_start) & ~vsync_r;

	// ============================================================
	// Register port write qualification.
	// Only indices in the protected range are refused; the overflow register
	// is handled bitwise below so its line-compare bit stays writable.
	assign wr_ok = data_wr & ~(protect & (index_r <= crt_vtiming_pkg::IDX_PROTECT_LAST));

	// Index register: software selects a register before each data access.
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			index_r <= 6'h00;
		end else if (index_wr) begin
			index_r <= index_wdata;
		end
	end

	// Unprotected registers.
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			preset_row_and_pan_r <= crt_vtiming_pkg::REG_RESET;
			max_scan_reg_r <= crt_vtiming_pkg::REG_RESET;
			cursor_start_row_r <= crt_vtiming_pkg::REG_RESET;
			cursor_end_row_r <= crt_vtiming_pkg::REG_RESET;
			start_address_middle_r <= crt_vtiming_pkg::REG_RESET;
			start_address_low_r <= crt_vtiming_pkg::REG_RESET;
			cursor_location_high_r <= crt_vtiming_pkg::REG_RESET;
			cursor_location_low_r <= crt_vtiming_pkg::REG_RESET;
			vertical_sync_start_low_r <= crt_vtiming_pkg::REG_RESET;
			vertical_sync_end_irq_r <= crt_vtiming_pkg::REG_RESET;
			vertical_display_end_low_r <= crt_vtiming_pkg::REG_RESET;
			line_pitch_r <= crt_vtiming_pkg::REG_RESET;
		end else if (data_wr) begin
			if (index_r == crt_vtiming_pkg::IDX_PRESET_ROW_AND_PAN) begin
				preset_row_and_pan_r <= data_wdata & crt_vtiming_pkg::PRS_READ_MASK;
			end else if (index_r == crt_vtiming_pkg::IDX_MAX_SCAN_LINE_CTRL) begin
				max_scan_reg_r <= data_wdata;
			end else if (index_r == crt_vtiming_pkg::IDX_CURSOR_START_ROW) begin
				cursor_start_row_r <= data_wdata & crt_vtiming_pkg::CSR_READ_MASK;
			end else if (index_r == crt_vtiming_pkg::IDX_CURSOR_END_ROW) begin
				cursor_end_row_r <= data_wdata & crt_vtiming_pkg::CER_READ_MASK;
			end else if (index_r == crt_vtiming_pkg::IDX_START_ADDRESS_MIDDLE) begin
				start_address_middle_r <= data_wdata;
			end else if (index_r == crt_vtiming_pkg::IDX_START_ADDRESS_LOW) begin
				start_address_low_r <= data_wdata;
			end else if (index_r == crt_vtiming_pkg::IDX_CURSOR_LOCATION_HIGH) begin
				cursor_location_high_r <= data_wdata;
			end else if (index_r == crt_vtiming_pkg::IDX_CURSOR_LOCATION_LOW) begin
				cursor_location_low_r <= data_wdata;
			end else if (index_r == crt_vtiming_pkg::IDX_VERTICAL_SYNC_START_LOW) begin
				vertical_sync_start_low_r <= data_wdata;
			end else if (index_r == crt_vtiming_pkg::IDX_VERTICAL_SYNC_END_IRQ) begin
				// The refresh-select bit is stored for readback and drives nothing.
				vertical_sync_end_irq_r <= data_wdata;
			end else if (index_r == crt_vtiming_pkg::IDX_VERTICAL_DISPLAY_END_LOW) begin
				vertical_display_end_low_r <= data_wdata;
			end else if (index_r == crt_vtiming_pkg::IDX_LINE_PITCH_LOW) begin
				line_pitch_r <= data_wdata;
			end
		end
	end

	// Protected vertical total register.
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			vertical_total_low_r <= crt_vtiming_pkg::REG_RESET;
		end else if (wr_ok && index_r == crt_vtiming_pkg::IDX_VERTICAL_TOTAL_LOW) begin
			vertical_total_low_r <= data_wdata;
		end
	end

	// Overflow register: line-compare bit 8 ignores the protect bit.
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			vertical_overflow_reg_r <= crt_vtiming_pkg::REG_RESET;
		end else if (data_wr && index_r == crt_vtiming_pkg::IDX_VERTICAL_OVERFLOW) begin
			if (protect) begin
				vertical_overflow_reg_r[crt_vtiming_pkg::OVF_LINECOMP_B8] <=
					data_wdata[crt_vtiming_pkg::OVF_LINECOMP_B8];
			end else begin
				vertical_overflow_reg_r <= data_wdata;
			end
		end
	end

	// ============================================================
	// Read data mux; unmapped indices read zero.
	always_comb begin
		rd_mux = 8'h00;
		if (index_r == crt_vtiming_pkg::IDX_VERTICAL_TOTAL_LOW) begin
			rd_mux = vertical_total_low_r;
		end else if (index_r == crt_vtiming_pkg::IDX_VERTICAL_OVERFLOW) begin
			rd_mux = vertical_overflow_reg_r;
		end else if (index_r == crt_vtiming_pkg::IDX_PRESET_ROW_AND_PAN) begin
			rd_mux = preset_row_and_pan_r & crt_vtiming_pkg::PRS_READ_MASK;
		end else if (index_r == crt_vtiming_pkg::IDX_MAX_SCAN_LINE_CTRL) begin
			rd_mux = max_scan_reg_r;
		end else if (index_r == crt_vtiming_pkg::IDX_CURSOR_START_ROW) begin
			rd_mux = cursor_start_row_r;
		end else if (index_r == crt_vtiming_pkg::IDX_CURSOR_END_ROW) begin
			rd_mux = cursor_end_row_r;
		end else if (index_r == crt_vtiming_pkg::IDX_START_ADDRESS_MIDDLE) begin
			rd_mux = start_address_middle_r;
		end else if (index_r == crt_vtiming_pkg::IDX_START_ADDRESS_LOW) begin
			rd_mux = start_address_low_r;
		end else if (index_r == crt_vtiming_pkg::IDX_CURSOR_LOCATION_HIGH) begin
			rd_mux = cursor_location_high_r;
		end else if (index_r == crt_vtiming_pkg::IDX_CURSOR_LOCATION_LOW) begin
			rd_mux = cursor_location_low_r;
		end else if (index_r == crt_vtiming_pkg::IDX_VERTICAL_SYNC_START_LOW) begin
			rd_mux = vertical_sync_start_low_r;
		end else if (index_r == crt_vtiming_pkg::IDX_VERTICAL_SYNC_END_IRQ) begin
			rd_mux = vertical_sync_end_irq_r;
		end else if (index_r == crt_vtiming_pkg::IDX_VERTICAL_DISPLAY_END_LOW) begin
			rd_mux = vertical_display_end_low_r;
		end else if (index_r == crt_vtiming_pkg::IDX_LINE_PITCH_LOW) begin
			rd_mux = line_pitch_r;
		end
	end

	// Read data is registered, so it follows the index and data one cycle late.
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			rdata_r <= 8'h00;
		end else begin
			rdata_r <= rd_mux;
		end
	end

	// ============================================================
	// Line divider for sync halving.
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			line_div_r <= 1'b0;
		end else if (hretrace) begin
			line_div_r <= ~line_div_r;
		end
	end

	// Vertical line counter; wraps after the total line.
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			vcount_r <= crt_vtiming_pkg::VCNT_RESET;
		end else if (frame_end) begin
			vcount_r <= crt_vtiming_pkg::VCNT_RESET;
		end else if (line_tick) begin
			vcount_r <= vcount_r + 12'h001;
		end
	end

	// Vertical sync: set on the start match, cleared on the low-nibble match.
	// The end compare is only looked at once sync is high, so a nibble that
	// matches at the start line does not produce a zero-length pulse.
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			vsync_r <= 1'b0;
		end else if (vsync_begin) begin
			vsync_r <= 1'b1;
		end else if (line_tick && vsync_r && vcount_r[3:0] == vsync_end) begin
			vsync_r <= 1'b0;
		end
	end

	// Vertical display enable: high from line zero until the end value.
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			vdisp_en_r <= 1'b0;
		end else if (frame_end) begin
			vdisp_en_r <= (vdisp_end != 11'h000);
		end else if (line_tick && vcount_r == {1'b0, vdisp_end}) begin
			vdisp_en_r <= 1'b0;
		end else if (line_tick && vcount_r == crt_vtiming_pkg::VCNT_RESET) begin
			vdisp_en_r <= 1'b1;
		end
	end

	// ============================================================
	// Row scan counter with optional halving of its clock.
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			row_div_r <= 1'b0;
		end else if (frame_end) begin
			row_div_r <= 1'b0;
		end else if (line_tick) begin
			row_div_r <= ~row_div_r;
		end
	end

	// Preset after each frame; the max compare clears rather than presets.
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			row_scan_r <= crt_vtiming_pkg::ROW_RESET;
		end else if (frame_end) begin
			row_scan_r <= preset_row;
		end else if (row_tick && row_scan_r == max_scan) begin
			row_scan_r <= crt_vtiming_pkg::ROW_RESET;
		end else if (row_tick) begin
			row_scan_r <= row_scan_r + 5'h01;
		end
	end

	// ============================================================
	// Start address latch. With line doubling the load waits for the row
	// clock so both halves of a doubled line fetch the same address.
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			addr_load_pend_r <= 1'b0;
			start_addr_r <= 21'h000000;
		end else if (frame_end && !line_doubling) begin
			addr_load_pend_r <= 1'b0;
			start_addr_r <= start_addr_full;
		end else if (frame_end) begin
			addr_load_pend_r <= 1'b1;
		end else if (addr_load_pend_r && row_tick) begin
			addr_load_pend_r <= 1'b0;
			start_addr_r <= start_addr_full;
		end
	end

	// Byte panning is passed on to the pixel shifter.
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			byte_pan_r <= 2'h0;
		end else begin
			byte_pan_r <= preset_row_and_pan_r[crt_vtiming_pkg::PRS_PAN_LSB +: 2];
		end
	end

	// ============================================================
	// Cursor detection and skew.
	assign cursor_now = alpha_mode & char_valid & (char_addr == cursor_loc)
		& ~cursor_start_row_r[crt_vtiming_pkg::CUR_OFF_BIT]
		& (cur_start <= cur_end)
		& (row_scan_r >= cur_start) & (row_scan_r <= cur_end);

	// Each stage is one character clock of delay.
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			cursor_pipe_r <= '0;
		end else begin
			cursor_pipe_r <= {cursor_pipe_r[SKEW_DEPTH_W-2:0], cursor_now};
		end
	end

	// Skew zero takes the first stage; each step adds one clock.
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			cursor_r <= 1'b0;
		end else begin
			cursor_r <= cursor_pipe_r[cur_skew];
		end
	end

	// ============================================================
	// Vertical retrace interrupt. The clear bit at zero holds the request
	// low, so the handler must rearm it; a retrace during that time is lost.
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			vint_req_r <= 1'b0;
		end else if (!int_clear_n) begin
			vint_req_r <= 1'b0;
		end else if (vsync_begin) begin
			vint_req_r <= 1'b1;
		end
	end

	// A request already pending shows one clock after the enable goes low.
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			irq_r <= 1'b0;
		end else begin
			irq_r <= vint_req_r & int_disable_n_low;
		end
	end

endmodule : crt_vertical_timing_cursor_regs

// *** tb/crt_vtiming_checker_props.sv ***
`timescale 1ns/1ps
// ============================================================
// Port checks for the vertical timing slice: each checked output is tied to its cause.
module crt_vtiming_checker (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic data_wr,
	input wire logic [7:0] data_wdata,
	input wire logic [5:0] index_r,
	input wire logic hretrace,
	input wire logic [11:0] vcount_r,
	input wire logic vsync_r,
	input wire logic vdisp_en_r,
	input wire logic vint_req_r,
	input wire logic irq_r,
	input wire logic [1:0] byte_pan_r,
	input wire logic [7:0] line_pitch_r
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);
	// Two edges of slack, so a line pulse registered inside the design is allowed.
	sequence line_ack;
		$past(hretrace) || $past(hretrace, 2);
	endsequence
	// A write of the sync end register with the request clear bit low.
	sequence clear_write;
		data_wr && index_r == crt_vtiming_pkg::IDX_VERTICAL_SYNC_END_IRQ
			&& !data_wdata[crt_vtiming_pkg::VSE_INT_CLEAR];
	endsequence
	// ============================================================
	// Register port and interrupt.
	reg_write_a: assert property (data_wr && index_r == crt_vtiming_pkg::IDX_LINE_PITCH_LOW
		|=> line_pitch_r == $past(data_wdata)) else $error("Pitch write lost.");
	pan_field_a: assert property (data_wr && index_r == crt_vtiming_pkg::IDX_PRESET_ROW_AND_PAN
		|-> ##2 byte_pan_r == $past(data_wdata[6:5], 2)) else $error("Pan field wrong.");
	irq_gate_a: assert property (irq_r |-> $past(vint_req_r))
		else $error("Interrupt without request.");
	req_clear_a: assert property (clear_write |-> ##2 !vint_req_r)
		else $error("Request not cleared.");
	// ============================================================
	// Vertical count steps by one or wraps to zero; sync and display enable move only on retrace lines.
	line_step_a: assert property ($changed(vcount_r)
		|-> vcount_r == 12'h000 || vcount_r == $past(vcount_r) + 12'h001) else $error("Bad step.");
	vsync_start_a: assert property ($rose(vsync_r) |-> line_ack)
		else $error("Sync rose off a line.");
	vsync_end_a: assert property ($fell(vsync_r) |-> line_ack)
		else $error("Sync fell off a line.");
	disp_edge_a: assert property ($changed(vdisp_en_r) |-> line_ack)
		else $error("Display enable moved off a line.");
endmodule : crt_vtiming_checker

bind crt_vertical_timing_cursor_regs crt_vtiming_checker u_crt_vtiming_checker (
	.clk(clk), .reset_n(reset_n), .data_wr(data_wr), .data_wdata(data_wdata),
	.index_r(index_r), .hretrace(hretrace), .vcount_r(vcount_r), .vsync_r(vsync_r),
	.vdisp_en_r(vdisp_en_r), .vint_req_r(vint_req_r), .irq_r(irq_r),
	.byte_pan_r(byte_pan_r), .line_pitch_r(line_pitch_r)
);

// *** tb/crt_monitor_model.sv ***
`timescale 1ns/1ps
// ============================================================
// Display monitor: counts frames on the sync leading edge and lines shown.
module crt_monitor_model (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic hretrace,
	input wire logic vsync,
	input wire logic vdisp_en,
	output logic [7:0] frames_r,
	output logic [7:0] shown_lines_r
);
	logic vsync_prev_r;
	// A monitor locks to the sync edge, so a held level counts as one frame only.
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			vsync_prev_r <= 1'b0;
			frames_r <= 8'h00;
			shown_lines_r <= 8'h00;
		end else begin
			vsync_prev_r <= vsync;
			frames_r <= frames_r + 8'(vsync && !vsync_prev_r);
			shown_lines_r <= shown_lines_r + 8'(hretrace && vdisp_en);
		end
	end
endmodule : crt_monitor_model

// *** tb/tb_crt_vertical_timing_cursor_regs.sv ***
`timescale 1ns/1ps
// ============================================================
// Bench: register table, protect, frame timing, interrupt and cursor.
module tb_crt_vertical_timing_cursor_regs;
	typedef struct packed {
		logic [5:0] idx;
		logic [7:0] wd;
		logic [7:0] rd;
	} reg_row_t;
	logic clk;
	logic reset_n = 1'b0;
	logic index_wr = 1'b0, data_wr = 1'b0, hretrace = 1'b0, char_valid = 1'b0;
	logic sync_halving = 1'b0, alpha_mode = 1'b0;
	logic [5:0] index_wdata = 6'h00;
	logic [7:0] data_wdata = 8'h00;
	logic [15:0] char_addr = 16'hffff;
	logic [5:0] index_r;
	logic [7:0] rdata_r, line_pitch_r, frames_r, shown_lines_r, tr;
	logic [11:0] vcount_r;
	logic [4:0] row_scan_r;
	logic [20:0] start_addr_r;
	logic [1:0] byte_pan_r;
	logic vsync_r, vdisp_en_r, cursor_r, vint_req_r, irq_r;
	int err_total = 0;
	int compares = 0;
	// Write, then read back; reserved bits and the unmapped index read as zero.
	reg_row_t rows [15] = '{'{6'h06, 8'ha5, 8'ha5}, '{6'h07, 8'hff, 8'hff},
		'{6'h08, 8'hff, 8'h7f}, '{6'h09, 8'hc3, 8'hc3}, '{6'h0a, 8'hff, 8'h3f},
		'{6'h0b, 8'hff, 8'h7f}, '{6'h0c, 8'h12, 8'h12}, '{6'h0d, 8'h34, 8'h34},
		'{6'h0e, 8'h56, 8'h56}, '{6'h0f, 8'h78, 8'h78}, '{6'h10, 8'h9a, 8'h9a},
		'{6'h11, 8'h4f, 8'h4f}, '{6'h12, 8'hbc, 8'hbc}, '{6'h13, 8'hde, 8'hde},
		'{6'h14, 8'hff, 8'h00}};
	// Total 4, sync 2 to 3, display end 3, max scan 2, preset 1, start 1234.
	logic [13:0] setup [8] = '{{6'h06, 8'h04}, {6'h10, 8'h02}, {6'h11, 8'h13},
		{6'h12, 8'h03}, {6'h09, 8'h02}, {6'h08, 8'h01}, {6'h0c, 8'h12}, {6'h0d, 8'h34}};
	// Per line: count, sync, display enable, row.
	logic [18:0] exp_tick [5] = '{{12'h001, 2'b01, 5'h01}, {12'h002, 2'b01, 5'h02},
		{12'h003, 2'b11, 5'h00}, {12'h004, 2'b00, 5'h01}, {12'h000, 2'b01, 5'h01}};

	crt_vertical_timing_cursor_regs u_crt_vertical_timing_cursor_regs (
		.clk(clk), .reset_n(reset_n), .index_wr(index_wr), .index_wdata(index_wdata),
		.data_wr(data_wr), .data_wdata(data_wdata), .address_extension_reg(4'h5),
		.vertical_extension_reg(8'h00), .sync_halving(sync_halving), .alpha_mode(alpha_mode),
		.hretrace(hretrace), .char_addr(char_addr), .char_valid(char_valid),
		.index_r(index_r), .rdata_r(rdata_r), .vcount_r(vcount_r), .row_scan_r(row_scan_r),
		.vsync_r(vsync_r), .vdisp_en_r(vdisp_en_r), .start_addr_r(start_addr_r),
		.cursor_r(cursor_r), .vint_req_r(vint_req_r), .irq_r(irq_r),
		.byte_pan_r(byte_pan_r), .line_pitch_r(line_pitch_r));
	crt_monitor_model u_crt_monitor_model (.clk(clk), .reset_n(reset_n), .hretrace(hretrace),
		.vsync(vsync_r), .vdisp_en(vdisp_en_r), .frames_r(frames_r),
		.shown_lines_r(shown_lines_r));

	// ============================================================
	// Clock, watchdog and shared tasks.
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// The whole run needs about four hundred cycles; fifty times that means a hang.
	initial begin
		repeat (20000) @(posedge clk);
		err_total++;
		report_and_stop();
	end
	task automatic chk(input string what, input logic [39:0] exp, input logic [39:0] got);
		compares++;
		if (got !== exp) begin
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
			err_total++;
		end
	endtask : chk
	task automatic report_and_stop();
		$display("Comparisons %0d, mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : report_and_stop
	task automatic do_reset();
		@(posedge clk);
		reset_n <= 1'b0;
		repeat (6) @(posedge clk);
		reset_n <= 1'b1;
	endtask : do_reset
	task automatic settle();
		repeat (3) @(posedge clk);
		#1;
	endtask : settle
	// Index first, then data one edge later through the same port.
	task automatic wr(input logic [5:0] idx, input logic [7:0] d);
		@(posedge clk);
		index_wr <= 1'b1;
		index_wdata <= idx;
		@(posedge clk);
		index_wr <= 1'b0;
		data_wr <= 1'b1;
		data_wdata <= d;
		@(posedge clk);
		data_wr <= 1'b0;
	endtask : wr
	task automatic rd_chk(input logic [5:0] idx, input logic [7:0] exp);
		@(posedge clk);
		index_wr <= 1'b1;
		index_wdata <= idx;
		@(posedge clk);
		index_wr <= 1'b0;
		settle();
		chk("index", idx, index_r);
		chk("rdata", exp, rdata_r);
	endtask : rd_chk
	task automatic tick();
		@(posedge clk);
		hretrace <= 1'b1;
		@(posedge clk);
		hretrace <= 1'b0;
		settle();
	endtask : tick
	// One character at the cursor place; tr records the cursor after each edge.
	task automatic probe();
		@(posedge clk);
		char_addr <= 16'h5678;
		char_valid <= 1'b1;
		@(posedge clk);
		char_addr <= 16'hffff;
		char_valid <= 1'b0;
		for (int i = 0; i < 8; i++) begin
			#1;
			tr[i] = cursor_r;
			@(posedge clk);
		end
	endtask : probe

	// ============================================================
	// Main sequence.
	initial begin
		do_reset();
		rd_chk(6'h06, 8'h00);
		chk("vcount", 12'h000, vcount_r);
		$display("Test done: reset");
		foreach (rows[i]) begin
			wr(rows[i].idx, rows[i].wd);
			rd_chk(rows[i].idx, rows[i].rd);
		end
		chk("pan pitch", {2'b11, 8'hde}, {byte_pan_r, line_pitch_r});
		$display("Test done: register table");
		wr(6'h11, 8'h80);
		wr(6'h06, 8'h11);
		rd_chk(6'h06, 8'ha5);
		wr(6'h07, 8'h00);
		rd_chk(6'h07, 8'hef);
		wr(6'h11, 8'h00);
		wr(6'h06, 8'h11);
		rd_chk(6'h06, 8'h11);
		$display("Test done: protect");
		do_reset();
		foreach (setup[i]) begin
			wr(setup[i][13:8], setup[i][7:0]);
		end
		for (int k = 0; k < 5; k++) begin
			tick();
			chk("line", exp_tick[k], {vcount_r, vsync_r, vdisp_en_r, row_scan_r});
		end
		chk("frame", {8'h01, 8'h03, 21'h051234, 1'b1},
			{frames_r, shown_lines_r, start_addr_r, irq_r});
		wr(6'h11, 8'h33);
		settle();
		chk("masked", 2'b10, {vint_req_r, irq_r});
		wr(6'h11, 8'h13);
		settle();
		chk("unmasked", 1'b1, irq_r);
		wr(6'h11, 8'h03);
		settle();
		chk("cleared", 2'b00, {vint_req_r, irq_r});
		@(posedge clk);
		sync_halving <= 1'b1;
		tick();
		tick();
		chk("halved", 12'h001, vcount_r);
		// Doubling: the third counted line must not clock the row counter.
		wr(6'h09, 8'h82);
		repeat (4) tick();
		chk("doubled", {12'h003, 5'h00}, {vcount_r, row_scan_r});
		$display("Test done: frame timing");
		@(posedge clk);
		alpha_mode <= 1'b1;
		wr(6'h0e, 8'h56);
		wr(6'h0f, 8'h78);
		wr(6'h0a, 8'h00);
		for (int s = 0; s < 4; s++) begin
			wr(6'h0b, {1'b0, 2'(s), 5'h1f});
			probe();
			chk("skew", 8'h01 << (s + 1), tr);
		end
		wr(6'h0a, 8'h20);
		probe();
		chk("off", 8'h00, tr);
		wr(6'h0a, 8'h05);
		wr(6'h0b, 8'h03);
		probe();
		chk("inverted", 8'h00, tr);
		wr(6'h0a, 8'h00);
		@(posedge clk);
		alpha_mode <= 1'b0;
		probe();
		chk("graphics", 8'h00, tr);
		$display("Test done: cursor");
		report_and_stop();
	end
endmodule : tb_crt_vertical_timing_cursor_regs
